// ===== logic/mtcfg_pkg.sv
`default_nettype none
package mtcfg_pkg;
  // ----------------------------------------------------------------
  // register offsets on the special function register bus
  // ----------------------------------------------------------------
  localparam logic [7:0] MTCFG_OFS_CNT_LO = 8'ha6;  // timer_count_low_byte
  localparam logic [7:0] MTCFG_OFS_CNT_HI = 8'ha7;  // timer_count_high_byte
  localparam logic [7:0] MTCFG_OFS_CONFIG = 8'hc3;  // timer_configuration

  // ----------------------------------------------------------------
  // timer_configuration field positions
  // ----------------------------------------------------------------
  localparam int MTCFG_BIT_CMP_FLAG = 7;  // compare_event_flag
  localparam int MTCFG_BIT_PER_FLAG = 6;  // period_event_flag
  localparam int MTCFG_BIT_OFC_FLAG = 5;  // overflow_compare_flag
  localparam int MTCFG_BIT_UNUSED   = 4;  // reads as zero
  localparam int MTCFG_BIT_CMP_SEL  = 3;  // compare_byte_select
  localparam int MTCFG_BIT_RESV     = 2;  // reserved, software writes 0
  localparam int MTCFG_BIT_SYNC     = 1;  // synchronized start/stop
  localparam int MTCFG_BIT_RUN      = 0;  // run control / status

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic       MTCFG_RST_SYNC  = 1'b1;
  localparam logic       MTCFG_RST_FLAG  = 1'b0;
  localparam logic [7:0] MTCFG_RST_BYTE  = 8'h00;
  localparam logic [15:0] MTCFG_RST_WORD = 16'h0000;

  // ----------------------------------------------------------------
  // run control states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    MTCFG_IDLE       = 4'b0001,  // stopped
    MTCFG_START_WAIT = 4'b0010,  // start requested, awaiting edge
    MTCFG_RUN        = 4'b0100,  // counting
    MTCFG_STOP_WAIT  = 4'b1000   // stop requested, awaiting edge
  } mtcfg_state_e;
endpackage : mtcfg_pkg
`default_nettype wire

// ===== logic/mtcfg_cnt_if.sv
`timescale 1ns/10ps
`default_nettype none
// control and status between run control and the counter core
interface mtcfg_cnt_if;
  logic        run;       // counter may advance
  logic        ld_lo;     // load low byte of count
  logic        ld_hi;     // load high byte of count
  logic        ld_full;   // load whole count (synchronized reload)
  logic [15:0] ld_data;   // load data
  logic        delta_ld;  // load delta halt count
  logic [15:0] count;     // current count
  logic        step;      // count advances this cycle
  logic        halted;    // delta counter non-zero
  modport ctrl (output run, ld_lo, ld_hi, ld_full, ld_data, delta_ld,
                input count, step, halted);
  modport core (input run, ld_lo, ld_hi, ld_full, ld_data, delta_ld,
                output count, step, halted);
endinterface : mtcfg_cnt_if
`default_nettype wire

// ===== logic/mtcfg_counter.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------------
// sixteen-bit count with delta halt counter
// ------------------------------------------------------------------
module mtcfg_counter
  import mtcfg_pkg::*;
#(
  parameter int WIDTH = 16  // count and delta width
) (
  input wire logic   sys_clk,
  input wire logic   reset,
  mtcfg_cnt_if.core  cnt
);
  logic [WIDTH-1:0] count_reg;   // timer value
  logic [WIDTH-1:0] count_next;
  logic [WIDTH-1:0] delta_reg;   // remaining halt cycles
  logic [WIDTH-1:0] delta_next;
  logic             step;        // advance this cycle

  // count and delta next values
  always_comb begin
    step       = cnt.run && (delta_reg == '0);
    count_next = count_reg;
    delta_next = delta_reg;
    if (cnt.run && delta_reg != '0) begin
      delta_next = delta_reg - 1'b1;  // same rate as the timer
    end
    if (cnt.delta_ld) begin
      delta_next = cnt.ld_data;  // re-arms only on a new write
    end
    if (cnt.ld_full) begin
      count_next = cnt.ld_data;
    end else if (cnt.ld_lo) begin
      count_next[7:0] = cnt.ld_data[7:0];
    end else if (cnt.ld_hi) begin
      count_next[15:8] = cnt.ld_data[15:8];
    end else if (step) begin
      count_next = count_reg + 1'b1;  // wraps; period logic sits outside
    end
  end

  // registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      count_reg <= MTCFG_RST_WORD;
      delta_reg <= MTCFG_RST_WORD;
    end else begin
      count_reg <= count_next;
      delta_reg <= delta_next;
    end
  end

  assign cnt.count  = count_reg;
  assign cnt.step   = step;
  assign cnt.halted = (delta_reg != '0);

  // halt lasts exactly the loaded number of cycles while running
  a_delta_halt_len: assert property (
    @(posedge sys_clk) disable iff (reset)
    (delta_reg == 16'h0002 && cnt.run && !cnt.delta_ld)
      ##1 (cnt.run && !cnt.delta_ld) |=> (delta_reg == '0))
    else $error("delta counter did not reach zero on time");

  // a zero delta stays zero without a new write
  a_delta_stays_zero: assert property (
    @(posedge sys_clk) disable iff (reset)
    (delta_reg == '0 && !cnt.delta_ld) |=> (delta_reg == '0))
    else $error("delta counter restarted without a write");
endmodule : mtcfg_counter
`default_nettype wire

// ===== logic/mtcfg_timer.sv
`timescale 1ns/10ps
`default_nettype none
module mtcfg_timer
  import mtcfg_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [7:0]  sfr_addr,         // register offset
  input  wire logic        sfr_wr,           // write strobe, one cycle
  input  wire logic        sfr_rd,           // read strobe, one cycle
  input  wire logic [7:0]  sfr_wdata,        // write data
  input  wire logic [7:0]  compare_value,    // 8-bit compare operand
  input  wire logic        period_event,     // period pulse
  input  wire logic        ovf_cmp_event,    // overflow compare pulse
  input  wire logic        sleep_edge,       // 32.768 kHz edge pulse
  input  wire logic [15:0] reload_count,     // value for synced start
  output logic      [7:0]  sfr_rdata,        // read data, next cycle
  output logic             timer_running,    // actual run state
  output logic      [15:0] timer_count       // count, registered one cycle behind
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  mtcfg_cnt_if cnt ();                 // link to counter core
  mtcfg_state_e state_reg, state_next; // run control
  logic [2:0] flag_reg, flag_next;     // cmp, per, ofc flags
  logic       sel_reg, sel_next;       // compare_byte_select
  logic       resv_reg, resv_next;     // reserved bit, stored only
  logic       sync_reg, sync_next;     // synchronized start/stop
  logic [7:0] lo_pend_reg, lo_pend_next; // pending delta low byte
  logic [7:0] snap_reg, snap_next;     // high byte snapshot
  logic [7:0] rdata_reg, rdata_next;   // read data
  logic       step_d_reg;              // counter advanced last cycle
  logic       run_reg;                 // status flop for output
  logic       cmp_hit;                 // compare match after a step
  logic       wr_cfg, wr_lo, wr_hi, rd_lo, rd_hi, rd_cfg;
  logic       is_running;              // RUN or STOP_WAIT

  // status is 1 for states where the counter really runs
  function automatic logic state_runs(input mtcfg_state_e s);
    return (s == MTCFG_RUN) || (s == MTCFG_STOP_WAIT);
  endfunction : state_runs

  assign wr_cfg     = sfr_wr && sfr_addr == MTCFG_OFS_CONFIG;
  assign wr_lo      = sfr_wr && sfr_addr == MTCFG_OFS_CNT_LO;
  assign wr_hi      = sfr_wr && sfr_addr == MTCFG_OFS_CNT_HI;
  assign rd_cfg     = sfr_rd && sfr_addr == MTCFG_OFS_CONFIG;
  assign rd_lo      = sfr_rd && sfr_addr == MTCFG_OFS_CNT_LO;
  assign rd_hi      = sfr_rd && sfr_addr == MTCFG_OFS_CNT_HI;
  assign is_running = state_runs(state_reg);

  // ----------------------------------------------------------------
  // counter core
  // ----------------------------------------------------------------
  mtcfg_counter #(
    .WIDTH (16)
  ) u_counter (
    .sys_clk (sys_clk),
    .reset   (reset),
    .cnt     (cnt.core)
  );

  // compare only right after the count moved, so one event per match
  assign cmp_hit = step_d_reg && (compare_value == (sel_reg ?
                   cnt.count[7:0] : cnt.count[15:8]));

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      MTCFG_IDLE: begin
        if (wr_cfg && sfr_wdata[MTCFG_BIT_RUN]) begin
          state_next = sfr_wdata[MTCFG_BIT_SYNC] ?
                       MTCFG_START_WAIT : MTCFG_RUN;
        end
      end
      MTCFG_START_WAIT: begin
        if (wr_cfg && !sfr_wdata[MTCFG_BIT_RUN]) begin
          state_next = MTCFG_IDLE;  // start withdrawn before the edge
        end else if (sleep_edge) begin
          state_next = MTCFG_RUN;
        end
      end
      MTCFG_RUN: begin
        if (wr_cfg && !sfr_wdata[MTCFG_BIT_RUN]) begin
          state_next = sfr_wdata[MTCFG_BIT_SYNC] ?
                       MTCFG_STOP_WAIT : MTCFG_IDLE;
        end
      end
      MTCFG_STOP_WAIT: begin
        if (wr_cfg && sfr_wdata[MTCFG_BIT_RUN]) begin
          state_next = MTCFG_RUN;  // stop withdrawn before the edge
        end else if (sleep_edge) begin
          state_next = MTCFG_IDLE;
        end
      end
      default: state_next = MTCFG_IDLE;
    endcase
  end

  // counter steering; idle covers START_WAIT too
  always_comb begin
    cnt.run      = is_running;
    // reload whenever the state really moves to RUN at the edge
    cnt.ld_full  = (state_reg == MTCFG_START_WAIT) && sleep_edge &&
                   !(wr_cfg && !sfr_wdata[MTCFG_BIT_RUN]);
    cnt.ld_lo    = wr_lo && !is_running;
    cnt.ld_hi    = wr_hi && !is_running;
    cnt.delta_ld = wr_hi && is_running;
    if (cnt.ld_full) begin
      cnt.ld_data = reload_count;
    end else if (is_running) begin
      cnt.ld_data = {sfr_wdata, lo_pend_reg};
    end else begin
      cnt.ld_data = {sfr_wdata, sfr_wdata};
    end
  end

  // ----------------------------------------------------------------
  // configuration, pending byte, snapshot and read data
  // ----------------------------------------------------------------
  always_comb begin
    flag_next    = flag_reg;
    sel_next     = sel_reg;
    resv_next    = resv_reg;
    sync_next    = sync_reg;
    lo_pend_next = lo_pend_reg;
    snap_next    = snap_reg;
    rdata_next   = rdata_reg;
    if (wr_cfg) begin
      // writing one leaves a flag alone, zero clears it
      flag_next = flag_reg & sfr_wdata[7:5];
      sel_next  = sfr_wdata[MTCFG_BIT_CMP_SEL];
      resv_next = sfr_wdata[MTCFG_BIT_RESV];  // stored, read back as is
      sync_next = sfr_wdata[MTCFG_BIT_SYNC];
    end
    // hardware set wins over a clear in the same cycle
    if (cmp_hit) flag_next[2] = 1'b1;
    if (period_event) flag_next[1] = 1'b1;
    if (ovf_cmp_event) flag_next[0] = 1'b1;
    if (wr_lo && is_running) begin
      lo_pend_next = sfr_wdata;
    end
    if (rd_lo) begin
      rdata_next = cnt.count[7:0];
      snap_next  = cnt.count[15:8];
    end else if (rd_hi) begin
      rdata_next = snap_reg;
    end else if (rd_cfg) begin
      rdata_next = {flag_reg, 1'b0, sel_reg, resv_reg, sync_reg,
                    is_running};
    end else if (sfr_rd) begin
      rdata_next = MTCFG_RST_BYTE;  // unmapped offsets read zero
    end
  end

  // registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg   <= MTCFG_IDLE;
      flag_reg    <= {3{MTCFG_RST_FLAG}};
      sel_reg     <= 1'b0;
      resv_reg    <= 1'b0;
      sync_reg    <= MTCFG_RST_SYNC;
      lo_pend_reg <= MTCFG_RST_BYTE;
      snap_reg    <= MTCFG_RST_BYTE;
      rdata_reg   <= MTCFG_RST_BYTE;
      step_d_reg  <= 1'b0;
      run_reg     <= 1'b0;
      timer_count <= MTCFG_RST_WORD;
    end else begin
      state_reg   <= state_next;
      flag_reg    <= flag_next;
      sel_reg     <= sel_next;
      resv_reg    <= resv_next;
      sync_reg    <= sync_next;
      lo_pend_reg <= lo_pend_next;
      snap_reg    <= snap_next;
      rdata_reg   <= rdata_next;
      step_d_reg  <= cnt.step;
      run_reg     <= state_runs(state_next);
      timer_count <= cnt.count;
    end
  end

  assign sfr_rdata     = rdata_reg;
  assign timer_running = run_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_cmp_flag_set: assert property (
    @(posedge sys_clk) disable iff (reset)
    cmp_hit |=> flag_reg[2])
    else $error("compare flag not set");

  a_per_flag_set: assert property (
    @(posedge sys_clk) disable iff (reset)
    period_event |=> flag_reg[1])
    else $error("period flag not set");

  a_ofc_flag_set: assert property (
    @(posedge sys_clk) disable iff (reset)
    ovf_cmp_event |=> flag_reg[0])
    else $error("overflow compare flag not set");

  a_flag_no_set: assert property (
    @(posedge sys_clk) disable iff (reset)
    (!flag_reg[1] && !period_event) |=> !flag_reg[1])
    else $error("period flag set by software");

  sequence s_sync_start_req;
    state_reg == MTCFG_IDLE && wr_cfg && sfr_wdata[MTCFG_BIT_RUN] &&
    sfr_wdata[MTCFG_BIT_SYNC];
  endsequence

  a_sync_start_wait: assert property (
    @(posedge sys_clk) disable iff (reset)
    s_sync_start_req ##1 (!sleep_edge && !wr_cfg) |=> !timer_running)
    else $error("synced start before the edge");

  a_imm_start: assert property (
    @(posedge sys_clk) disable iff (reset)
    (state_reg == MTCFG_IDLE && wr_cfg && sfr_wdata[MTCFG_BIT_RUN] &&
     !sfr_wdata[MTCFG_BIT_SYNC]) |=> ##1 timer_running)
    else $error("immediate start missing");

  a_run_readback: assert property (
    @(posedge sys_clk) disable iff (reset)
    rd_cfg |=> (sfr_rdata[MTCFG_BIT_RUN] == $past(is_running)))
    else $error("run bit does not show state");

  a_hi_snapshot: assert property (
    @(posedge sys_clk) disable iff (reset)
    rd_lo ##1 (!rd_lo [*2]) ##0 rd_hi |=>
      (sfr_rdata == $past(cnt.count[15:8], 3)))
    else $error("high byte read is not the snapshot");

  a_delta_pair: assert property (
    @(posedge sys_clk) disable iff (reset)
    (wr_lo && is_running) ##1 !sfr_wr ##1 (wr_hi && is_running) |->
      (cnt.delta_ld && cnt.ld_data[7:0] == $past(sfr_wdata, 2) &&
       cnt.ld_data[15:8] == sfr_wdata))
    else $error("delta low byte not paired");
endmodule : mtcfg_timer
`default_nettype wire

// ===== tb/mac_timer_config_and_value_access_test.sv
`timescale 1ns/10ps
`default_nettype none
module mac_timer_config_and_value_access_test;
  import mtcfg_pkg::*;
  // ----------------------------------------------------------------
  // design inputs, driven on the falling edge, and design outputs
  // ----------------------------------------------------------------
  logic        sys_clk = 1'b0;       // 250 MHz system clock
  logic        reset   = 1'b1;       // synchronous, active high
  logic [7:0]  sfr_addr = 8'h00;     // register offset
  logic        sfr_wr = 1'b0;        // write strobe
  logic        sfr_rd = 1'b0;        // read strobe
  logic [7:0]  sfr_wdata = 8'h00;    // write data
  logic [7:0]  compare_value = 8'h00;
  logic        period_event = 1'b0;
  logic        ovf_cmp_event = 1'b0;
  logic        sleep_edge = 1'b0;    // slow clock edge reference
  logic [15:0] reload_count = 16'h0000;
  logic [7:0]  sfr_rdata;            // read data
  logic        timer_running;        // actual run state
  logic [15:0] timer_count;          // count, registered one cycle behind
  // ----------------------------------------------------------------
  // bench state and reference model
  // ----------------------------------------------------------------
  int          miscompares = 0;      // mismatches seen
  int          checks_done = 0;      // comparisons made
  int          cycles = 0;           // hang guard
  int          seed = 45;            // fixed seed for repeatable runs
  int          m_cnt;                // model of the count
  int          d;                    // delta halt length
  logic [7:0]  lo, hi, hi2;          // random count bytes
  logic [15:0] t0, t;                // count samples
  logic        sel;                  // compare byte select

  mtcfg_timer DUT (
    .sys_clk       (sys_clk),
    .reset         (reset),
    .sfr_addr      (sfr_addr),
    .sfr_wr        (sfr_wr),
    .sfr_rd        (sfr_rd),
    .sfr_wdata     (sfr_wdata),
    .compare_value (compare_value),
    .period_event  (period_event),
    .ovf_cmp_event (ovf_cmp_event),
    .sleep_edge    (sleep_edge),
    .reload_count  (reload_count),
    .sfr_rdata     (sfr_rdata),
    .timer_running (timer_running),
    .timer_count   (timer_count)
  );

  // free-running clock, 4 ns period
  always #2 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  // verdict and end of run, shared by the main flow and the guard
  task automatic test_done();
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  // one comparison; case inequality so unknowns never match
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc

  // strobe lasts one cycle; next call waits a fresh edge to raise it
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge sys_clk);
    sfr_addr  = a;
    sfr_wdata = v;
    sfr_wr    = 1'b1;
    @(negedge sys_clk);
    sfr_wr = 1'b0;
  endtask : wr

  // read data is registered, so it is settled one cycle later
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk);
    sfr_addr = a;
    sfr_rd   = 1'b1;
    @(negedge sys_clk);
    sfr_rd = 1'b0;
    chk({8'h00, sfr_rdata}, {8'h00, e});
  endtask : rchk

  // one-cycle pulse on {sleep_edge, ovf_cmp_event, period_event}
  task automatic pulse(input logic [2:0] w);
    @(negedge sys_clk);
    {sleep_edge, ovf_cmp_event, period_event} = w;
    @(negedge sys_clk);
    {sleep_edge, ovf_cmp_event, period_event} = 3'b000;
  endtask : pulse

  // ----------------------------------------------------------------
  // hang guard: the whole run needs well under a thousand cycles
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      miscompares++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(2);
    reset = 1'b0;
    // reset state: sync set, stopped, count zero
    chk(timer_count, 16'h0000);
    chk({8'h00, sfr_rdata}, 16'h0000);
    chk({15'h0000, timer_running}, 16'h0000);
    rchk(MTCFG_OFS_CONFIG, 8'h02);
    rchk(MTCFG_OFS_CNT_LO, 8'h00);
    rchk(MTCFG_OFS_CNT_HI, 8'h00);
    // event flags: set by pulses, ones written are ignored, zero clears
    pulse(3'b011);
    rchk(MTCFG_OFS_CONFIG, 8'h62);
    wr(MTCFG_OFS_CONFIG, 8'he2);
    rchk(MTCFG_OFS_CONFIG, 8'h62);
    wr(MTCFG_OFS_CONFIG, 8'h02);
    rchk(MTCFG_OFS_CONFIG, 8'h02);
    // unmapped offset reads zero and a write there changes nothing
    wr(8'h94, 8'hff);
    rchk(8'h94, 8'h00);
    rchk(MTCFG_OFS_CONFIG, 8'h02);
    // idle byte loads, live low read and high snapshot
    for (int i = 0; i < 3; i++) begin
      lo  = 8'($random(seed));
      hi  = 8'($random(seed));
      hi2 = 8'($random(seed));
      wr(MTCFG_OFS_CNT_LO, lo);
      wr(MTCFG_OFS_CNT_HI, hi);
      m_cnt = {16'h0000, hi, lo};
      cyc(1);
      chk(timer_count, m_cnt[15:0]);
      rchk(MTCFG_OFS_CNT_LO, m_cnt[7:0]);
      wr(MTCFG_OFS_CNT_HI, hi2);
      rchk(MTCFG_OFS_CNT_HI, hi);
      m_cnt[15:8] = hi2;
      chk(timer_count, m_cnt[15:0]);
    end
    // compare byte select: only the selected byte may match
    for (int i = 0; i < 4; i++) begin
      sel = i[1];
      compare_value = i[0] ? 8'hf8 : 8'h13;
      wr(MTCFG_OFS_CNT_LO, 8'hf0);
      wr(MTCFG_OFS_CNT_HI, 8'h12);
      wr(MTCFG_OFS_CONFIG, {4'h0, sel, 3'b001});
      cyc(1);
      chk({15'h0000, timer_running}, 16'h0001);
      t0 = timer_count;
      cyc(10);
      chk(timer_count - t0, 16'h000a);
      cyc(15);
      rchk(MTCFG_OFS_CONFIG, {sel == i[0], 3'b000, sel, 3'b001});
      wr(MTCFG_OFS_CONFIG, {4'h0, sel, 3'b000});
      cyc(1);
      chk({15'h0000, timer_running}, 16'h0000);
    end
    // delta halt: low byte pends, high write loads {high, low}
    wr(MTCFG_OFS_CONFIG, 8'h01);
    cyc(3);
    d  = 8 + ($random(seed) & 31);
    t0 = timer_count;
    wr(MTCFG_OFS_CNT_LO, 8'(d));
    wr(MTCFG_OFS_CNT_HI, 8'h00);
    cyc(60);
    chk(timer_count - t0, 16'(64 - d));
    t0 = timer_count;
    cyc(40);
    chk(timer_count - t0, 16'h0028);
    wr(MTCFG_OFS_CONFIG, 8'h00);
    cyc(1);
    chk({15'h0000, timer_running}, 16'h0000);
    // synchronized start: status waits for the slow clock edge
    reload_count = 16'($random(seed));
    wr(MTCFG_OFS_CONFIG, 8'h03);
    cyc(5);
    chk({15'h0000, timer_running}, 16'h0000);
    rchk(MTCFG_OFS_CONFIG, 8'h02);
    pulse(3'b100);
    cyc(2);
    chk({15'h0000, timer_running}, 16'h0001);
    t = timer_count - reload_count;
    chk(t, 16'h0001);
    rchk(MTCFG_OFS_CONFIG, 8'h03);
    // synchronized stop: keeps running until the edge arrives
    wr(MTCFG_OFS_CONFIG, 8'h02);
    cyc(5);
    chk({15'h0000, timer_running}, 16'h0001);
    rchk(MTCFG_OFS_CONFIG, 8'h03);
    pulse(3'b100);
    cyc(2);
    chk({15'h0000, timer_running}, 16'h0000);
    t0 = timer_count;
    cyc(5);
    chk(timer_count, t0);
    rchk(MTCFG_OFS_CONFIG, 8'h02);
    // a synced start taken back before the edge never runs
    wr(MTCFG_OFS_CONFIG, 8'h03);
    wr(MTCFG_OFS_CONFIG, 8'h02);
    pulse(3'b100);
    cyc(2);
    chk({15'h0000, timer_running}, 16'h0000);
    // second reset in mid-run returns everything to the reset state
    wr(MTCFG_OFS_CONFIG, 8'h01);
    cyc(3);
    // a synced stop taken back before the edge keeps running
    wr(MTCFG_OFS_CONFIG, 8'h02);
    wr(MTCFG_OFS_CONFIG, 8'h03);
    pulse(3'b100);
    cyc(2);
    chk({15'h0000, timer_running}, 16'h0001);
    reset = 1'b1;
    cyc(2);
    reset = 1'b0;
    chk(timer_count, 16'h0000);
    chk({8'h00, sfr_rdata}, 16'h0000);
    chk({15'h0000, timer_running}, 16'h0000);
    rchk(MTCFG_OFS_CONFIG, 8'h02);
    test_done();
  end
endmodule : mac_timer_config_and_value_access_test
`default_nettype wire
